// ### verilog/status_gpio_threshold_regs.sv
`timescale 1ns/1ps
`default_nettype none

module status_gpio_threshold_regs
  import status_gpio_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Register access port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  input  wire logic       regRead,
  output var  logic [7:0] regRdata_q,
  // Converter control and results
  input  wire logic       autoMode,
  input  wire logic       convStart,
  input  wire logic       convStop,
  input  wire logic       convDone,
  input  wire logic       resultValid,
  input  wire logic [2:0] resultChan,
  input  wire logic [11:0] resultData,
  // Supply range comparators, bit 3 = group D .. bit 0 = group A
  input  wire logic [3:0] rangeDetect,
  // General-purpose open-drain pins
  input  wire logic [7:0] ioPinIn,
  output var  logic [7:0] ioPinOut_q,
  output var  logic [7:0] ioPinOe_q
);

  // ==========================================================
  // Storage
  conv_state_t convState_q, convState_d;
  logic        readyFlag_q, readyFlag_d;
  logic        globalAlarm_q, globalAlarm_d;
  logic [7:0]  ioPin_q, ioPin_d;
  logic [7:0]  ioPinOe_d;
  logic [11:0] upperThr_q [NUM_CHAN];
  logic [11:0] upperThr_d [NUM_CHAN];
  logic [11:0] lowerThr_q [NUM_CHAN];
  logic [11:0] lowerThr_d [NUM_CHAN];
  logic [NUM_INPUT-1:0] inputAlarm_q, inputAlarm_d;
  logic        tempHigh_q, tempHigh_d;
  logic        tempLow_q, tempLow_d;
  logic [7:0]  regRdata_d;

  // Decode helpers
  logic        threshHit;
  logic [7:0]  threshOfs;
  logic [2:0]  threshChan;
  logic [1:0]  threshByte;
  logic [7:0]  statusWord;
  logic [7:0]  alarm0Word;
  logic [7:0]  alarm1Word;
  logic        anyAlarm;
  logic        chanKnown;

  window_cmp_if win ();

  // ==========================================================
  // Comparator shared by all channels; only the stored channel matters
  window_compare cmpUnit (
    .win (win.cmp)
  );

  // Present the arriving result with its own thresholds; channels 6 and 7
  // have no limits, so they borrow the temperature slot instead of reading
  // past the end of the arrays and feeding unknowns to the comparator
  always_comb begin
    chanKnown    = (resultChan <= TEMP_CHAN);
    win.value    = resultData;
    win.upper    = chanKnown ? upperThr_q[resultChan] : upperThr_q[TEMP_CHAN];
    win.lower    = chanKnown ? lowerThr_q[resultChan] : lowerThr_q[TEMP_CHAN];
    win.isSigned = (resultChan == TEMP_CHAN);
  end

  // ==========================================================
  // Address decode for the threshold block
  // Each channel owns a four-byte slot: upper low, upper high, lower low, lower high
  always_comb begin
    threshHit  = (regAddr >= THRESH_BASE) && (regAddr <= THRESH_LAST);
    threshOfs  = regAddr - THRESH_BASE;
    threshChan = threshOfs[4:2];
    threshByte = threshOfs[1:0];
  end

  // ==========================================================
  // Converter activity tracking and result ready flag
  always_comb begin
    convState_d = convState_q;
    readyFlag_d = readyFlag_q;
    // Starts outside idle are ignored until the current run has ended
    unique case (convState_q)
      CONV_IDLE: begin
        if (convStart) begin
          convState_d = autoMode ? CONV_AUTO : CONV_DIRECT;
          readyFlag_d = 1'b0;
        end
      end
      CONV_AUTO: begin
        if (convStop) begin
          convState_d = CONV_IDLE;
        end
      end
      CONV_DIRECT: begin
        if (convDone) begin
          convState_d = CONV_IDLE;
          readyFlag_d = 1'b1;
        end else if (convStop) begin
          // An abandoned batch leaves no fresh data to report
          convState_d = CONV_IDLE;
        end
      end
      // The spare code can only come from an upset; recover to idle
      default: begin
        convState_d = CONV_IDLE;
      end
    endcase
    // Auto mode never reports fresh direct data
    if (autoMode) begin
      readyFlag_d = 1'b0;
    end
  end

  // Converter state and ready flag registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      convState_q <= CONV_IDLE;
      readyFlag_q <= 1'b0;
    end else begin
      convState_q <= convState_d;
      readyFlag_q <= readyFlag_d;
    end
  end

  // ==========================================================
  // Assembled read words
  always_comb begin
    statusWord = READ_DEFAULT;
    statusWord[STAT_RANGE_LSB +: 4] = rangeDetect;
    // Idle comes from the state itself, so the two can never disagree
    statusWord[STAT_IDLE]   = (convState_q == CONV_IDLE);
    statusWord[STAT_RSVD]   = 1'b1;
    statusWord[STAT_GLOBAL] = globalAlarm_q;
    // Masked live, so a read in the first auto cycle already shows 0
    statusWord[STAT_READY]  = readyFlag_q & ~autoMode;
    alarm0Word = READ_DEFAULT;
    alarm0Word[NUM_INPUT-1:0] = inputAlarm_q;
    alarm1Word = READ_DEFAULT;
    alarm1Word[ALM1_TEMP_HIGH] = tempHigh_q;
    alarm1Word[ALM1_TEMP_LOW]  = tempLow_q;
    anyAlarm = (|inputAlarm_d) | tempHigh_d | tempLow_d;
  end

  // ==========================================================
  // Channel alarms, refreshed only when a result is stored
  always_comb begin
    inputAlarm_d = inputAlarm_q;
    tempHigh_d   = tempHigh_q;
    tempLow_d    = tempLow_q;
    if (resultValid) begin
      // Results for the two unused channel codes change no flag
      if (resultChan == TEMP_CHAN) begin
        tempHigh_d = win.above;
        tempLow_d  = win.below;
      end else if (resultChan < TEMP_CHAN) begin
        // Inverted window (upper below lower) always flags, by design
        inputAlarm_d[resultChan] = win.above | win.below;
      end
    end
  end

  // Global alarm: an alarm present in the clearing cycle keeps it set, so a
  // status read that races a fresh alarm never loses it
  always_comb begin
    globalAlarm_d = globalAlarm_q;
    if (regRead && (regAddr == STATUS_ADDR)) begin
      globalAlarm_d = 1'b0;
    end
    if (anyAlarm) begin
      globalAlarm_d = 1'b1;
    end
  end

  // Alarm registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inputAlarm_q  <= '0;
      tempHigh_q    <= 1'b0;
      tempLow_q     <= 1'b0;
      globalAlarm_q <= 1'b0;
    end else begin
      inputAlarm_q  <= inputAlarm_d;
      tempHigh_q    <= tempHigh_d;
      tempLow_q     <= tempLow_d;
      globalAlarm_q <= globalAlarm_d;
    end
  end

  // ==========================================================
  // Writable registers: pin control and thresholds
  always_comb begin
    ioPin_d    = ioPin_q;
    upperThr_d = upperThr_q;
    lowerThr_d = lowerThr_q;
    if (regWrite && (regAddr == IO_PIN_ADDR)) begin
      ioPin_d = regWdata;
    end
    // Reserved nibbles are not stored and read back as zero
    if (regWrite && threshHit) begin
      unique case (threshByte)
        UPPER_LOW_BYTE:  upperThr_d[threshChan] =
                           joinBytes(upperThr_q[threshChan][11:8], regWdata);
        UPPER_HIGH_BYTE: upperThr_d[threshChan] =
                           joinBytes(regWdata[3:0], upperThr_q[threshChan][7:0]);
        LOWER_LOW_BYTE:  lowerThr_d[threshChan] =
                           joinBytes(lowerThr_q[threshChan][11:8], regWdata);
        LOWER_HIGH_BYTE: lowerThr_d[threshChan] =
                           joinBytes(regWdata[3:0], lowerThr_q[threshChan][7:0]);
      endcase
    end
    // Released pins are undriven; a zero pulls the pin low
    ioPinOe_d = ~ioPin_d;
  end

  // Pin and limit registers; reset releases every pin
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ioPin_q    <= IO_PIN_RESET;
      ioPinOe_q  <= ~IO_PIN_RESET;
      ioPinOut_q <= '0;
      for (int i = 0; i < NUM_INPUT; i++) begin
        upperThr_q[i] <= INPUT_UPPER_INIT;
        lowerThr_q[i] <= INPUT_LOWER_INIT;
      end
      upperThr_q[TEMP_CHAN] <= TEMP_UPPER_INIT;
      lowerThr_q[TEMP_CHAN] <= TEMP_LOWER_INIT;
    end else begin
      ioPin_q    <= ioPin_d;
      ioPinOe_q  <= ioPinOe_d;
      ioPinOut_q <= '0;                                      // Open drain only drives low
      upperThr_q <= upperThr_d;
      lowerThr_q <= lowerThr_d;
    end
  end

  // ==========================================================
  // Read data, registered one cycle after the read strobe
  always_comb begin
    regRdata_d = regRdata_q;
    if (regRead) begin
      // Unmapped addresses read as zero; between reads the last value stands
      regRdata_d = READ_DEFAULT;
      if (regAddr == STATUS_ADDR) begin
        regRdata_d = statusWord;
      end else if (regAddr == ALARM0_ADDR) begin
        regRdata_d = alarm0Word;
      end else if (regAddr == ALARM1_ADDR) begin
        regRdata_d = alarm1Word;
      end else if (regAddr == IO_PIN_ADDR) begin
        regRdata_d = ioPinIn;
      end else if (threshHit) begin
        unique case (threshByte)
          UPPER_LOW_BYTE:  regRdata_d = upperThr_q[threshChan][7:0];
          UPPER_HIGH_BYTE: regRdata_d = {4'h0, upperThr_q[threshChan][11:8]};
          LOWER_LOW_BYTE:  regRdata_d = lowerThr_q[threshChan][7:0];
          LOWER_HIGH_BYTE: regRdata_d = {4'h0, lowerThr_q[threshChan][11:8]};
        endcase
      end
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdata_q <= READ_DEFAULT;
    end else begin
      regRdata_q <= regRdata_d;
    end
  end

endmodule

`default_nettype wire

// ### verilog/status_gpio_pkg.sv
`default_nettype none

package status_gpio_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ALARM0_ADDR   = 8'h70;
  localparam logic [7:0] ALARM1_ADDR   = 8'h71;
  localparam logic [7:0] STATUS_ADDR   = 8'h72;
  localparam logic [7:0] IO_PIN_ADDR   = 8'h7a;
  localparam logic [7:0] THRESH_BASE   = 8'h80;
  localparam logic [7:0] THRESH_LAST   = 8'h97;

  // ==========================================================
  // Threshold byte layout within each four-byte channel slot
  localparam logic [1:0] UPPER_LOW_BYTE  = 2'h0;
  localparam logic [1:0] UPPER_HIGH_BYTE = 2'h1;
  localparam logic [1:0] LOWER_LOW_BYTE  = 2'h2;
  localparam logic [1:0] LOWER_HIGH_BYTE = 2'h3;

  // ==========================================================
  // Channels: five unipolar inputs then the temperature sensor
  localparam int         NUM_CHAN      = 6;
  localparam int         NUM_INPUT     = 5;
  localparam logic [2:0] TEMP_CHAN     = 3'h5;
  localparam int         THRESH_W      = 12;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  IO_PIN_RESET     = 8'hff;
  localparam logic [11:0] INPUT_UPPER_INIT = 12'hfff;
  localparam logic [11:0] INPUT_LOWER_INIT = 12'h000;
  localparam logic [11:0] TEMP_UPPER_INIT  = 12'h7ff;
  localparam logic [11:0] TEMP_LOWER_INIT  = 12'h800;
  localparam logic [7:0]  READ_DEFAULT     = 8'h00;

  // ==========================================================
  // Status bit positions
  localparam int STAT_RANGE_LSB = 4;
  localparam int STAT_IDLE      = 3;
  localparam int STAT_RSVD      = 2;
  localparam int STAT_GLOBAL    = 1;
  localparam int STAT_READY     = 0;

  // Alarm status 1 bit positions
  localparam int ALM1_TEMP_HIGH = 1;
  localparam int ALM1_TEMP_LOW  = 0;

  // ==========================================================
  // Converter activity states, Gray along idle->auto->direct
  typedef enum logic [1:0] {
    CONV_IDLE   = 2'b00,
    CONV_AUTO   = 2'b01,
    CONV_DIRECT = 2'b11
  } conv_state_t;

  // Joins the two bytes of a 12-bit threshold
  function automatic logic [11:0] joinBytes(input logic [3:0] hi, input logic [7:0] lo);
    joinBytes = {hi, lo};
  endfunction

endpackage

`default_nettype wire

// ### verilog/window_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries one window comparison between register bank and comparator
interface window_cmp_if;
  logic [11:0] value;
  logic [11:0] upper;
  logic [11:0] lower;
  logic        isSigned;
  logic        above;
  logic        below;

  modport bank (output value, output upper, output lower, output isSigned,
                input above, input below);
  modport cmp  (input value, input upper, input lower, input isSigned,
                output above, output below);
endinterface

`default_nettype wire

// ### verilog/window_compare.sv
`timescale 1ns/1ps
`default_nettype none

module window_compare
  import status_gpio_pkg::*;
(
  // Comparison operands and results
  window_cmp_if.cmp win
);

  // ==========================================================
  // Window test; temperature codes compare signed, inputs unsigned
  always_comb begin
    if (win.isSigned) begin
      win.above = $signed(win.value) > $signed(win.upper);
      win.below = $signed(win.value) < $signed(win.lower);
    end else begin
      win.above = win.value > win.upper;
      win.below = win.value < win.lower;
    end
  end

endmodule

`default_nettype wire

// ### verif/status_gpio_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port-level checks on the status, pin and threshold bank
module status_gpio_monitor
  import status_gpio_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic       regRead,
  input wire logic [7:0] regRdata_q,
  // Converter control and range inputs
  input wire logic       autoMode,
  input wire logic       convStart,
  input wire logic       convStop,
  input wire logic       convDone,
  input wire logic [3:0] rangeDetect,
  // Pins
  input wire logic [7:0] ioPinIn,
  input wire logic [7:0] ioPinOut_q,
  input wire logic [7:0] ioPinOe_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Requests the properties start from
  sequence s_stat_rd;
    regRead && regAddr == STATUS_ADDR;
  endsequence
  sequence s_io_rd;
    regRead && regAddr == IO_PIN_ADDR;
  endsequence
  sequence s_direct_go;
    convStart && !autoMode && !convStop && !convDone;
  endsequence

  a_drive_follows_write: assert property (
    regWrite && regAddr == IO_PIN_ADDR |=> ioPinOe_q == ~$past(regWdata))
    else $error("pin enables do not match written value");
  a_drive_held: assert property (
    !(regWrite && regAddr == IO_PIN_ADDR) |=> $stable(ioPinOe_q))
    else $error("pin enables changed without a write");
  a_pins_only_low: assert property (ioPinOut_q == 8'h00)
    else $error("pin driven high");
  a_io_reads_pins: assert property (s_io_rd |=> regRdata_q == $past(ioPinIn))
    else $error("pin read does not show sampled levels");
  a_range_in_status: assert property (
    s_stat_rd |=> regRdata_q[7:4] == $past(rangeDetect))
    else $error("range bits wrong in status");
  a_reserved_one: assert property (s_stat_rd |=> regRdata_q[2])
    else $error("reserved status bit not one");
  a_auto_no_ready: assert property (s_stat_rd ##0 autoMode |=> !regRdata_q[0])
    else $error("ready flag set in auto mode");
  a_direct_busy: assert property (
    s_direct_go ##1 !(convDone || convStop) ##1 s_stat_rd |=> !regRdata_q[3])
    else $error("idle flag high after direct start");
endmodule

`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side of the register port: one-cycle strobes, spaced by an edge
module host_model (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWdata,
  output logic            regRead,
  input  wire logic [7:0] regRdata_q
);
  // Quiet bus from time zero
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    regRead = 1'b0;
  end

  // Write: strobe stands for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // Read: data is registered, so sample just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata_q;
  endtask
endmodule

`default_nettype wire

// ### verif/status_gpio_threshold_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench: reset values from a table, then hand-made sequences
module status_gpio_threshold_regs_tb_top
  import status_gpio_pkg::*;
;
  typedef struct packed {logic [7:0] addr; logic [7:0] exp;} row_t;
  logic        clock = 1'b0;
  logic        nrst, regWrite, regRead, autoMode, convStart, convStop, convDone;
  logic        resultValid;
  logic [7:0]  regAddr, regWdata, regRdata_q, ioPinIn, ioPinOut_q, ioPinOe_q, pinExt, rd;
  logic [2:0]  resultChan;
  logic [11:0] resultData;
  logic [3:0]  rangeDetect;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  row_t        rows [13] = '{'{8'h80, 8'hff}, '{8'h81, 8'h0f}, '{8'h82, 8'h00},
    '{8'h83, 8'h00}, '{8'h94, 8'hff}, '{8'h95, 8'h07}, '{8'h96, 8'h00},
    '{8'h97, 8'h08}, '{8'h70, 8'h00}, '{8'h71, 8'h00}, '{8'h72, 8'h5c},
    '{8'h7a, 8'hff}, '{8'h60, 8'h00}};

  always #12.5 clock = ~clock;
  // Pull-ups hold released pins high unless the outside pulls them low
  assign ioPinIn = ~ioPinOe_q & pinExt;

  status_gpio_threshold_regs dut (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata_q(regRdata_q),
    .autoMode(autoMode), .convStart(convStart), .convStop(convStop), .convDone(convDone),
    .resultValid(resultValid), .resultChan(resultChan), .resultData(resultData),
    .rangeDetect(rangeDetect), .ioPinIn(ioPinIn), .ioPinOut_q(ioPinOut_q),
    .ioPinOe_q(ioPinOe_q));
  host_model host (.clock(clock), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRead(regRead), .regRdata_q(regRdata_q));

  task automatic give_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle converter pulse: 0 start, 1 stop, 2 done
  task automatic pulse(input int which);
    @(posedge clock);
    convStart <= (which == 0);
    convStop <= (which == 1);
    convDone <= (which == 2);
    @(posedge clock);
    {convStart, convStop, convDone} <= 3'h0;
  endtask

  task automatic result(input logic [2:0] ch, input logic [11:0] d);
    @(posedge clock);
    resultValid <= 1'b1;
    resultChan <= ch;
    resultData <= d;
    @(posedge clock);
    resultValid <= 1'b0;
  endtask

  // Hang guard, far above the roughly 120 cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {nrst, autoMode, convStart, convStop, convDone, resultValid} = 6'h0;
    resultChan = 3'h0;
    resultData = 12'h000;
    rangeDetect = 4'h5;
    pinExt = 8'hff;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      host.rd(rows[i].addr, rd);
      chk(rd, rows[i].exp);
    end
    // Open-drain pins and read-back of real levels
    host.wr(IO_PIN_ADDR, 8'ha5);
    #1 chk(ioPinOe_q, 8'h5a);
    chk(ioPinOut_q, 8'h00);
    @(posedge clock) pinExt <= 8'hf0;
    host.rd(IO_PIN_ADDR, rd);
    chk(rd, 8'ha0);
    // Direct conversion, then auto mode start and stop
    pulse(0);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'h54);
    pulse(2);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'h5d);
    @(posedge clock) autoMode <= 1'b1;
    rangeDetect <= 4'ha;
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'hac);
    pulse(0);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'ha4);
    pulse(1);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'hac);
    // Window on input 16, a value equal to the limit is inside
    host.wr(8'h80, 8'h00);
    host.wr(8'h81, 8'h01);
    result(3'h0, 12'h101);
    host.rd(ALARM0_ADDR, rd);
    chk(rd, 8'h01);
    result(3'h0, 12'h100);
    host.rd(ALARM0_ADDR, rd);
    chk(rd, 8'h00);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'hae);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'hac);
    // Upper programmed below lower on input 17 on purpose
    host.wr(8'h84, 8'h00);
    host.wr(8'h85, 8'h00);
    host.wr(8'h86, 8'h10);
    result(3'h1, 12'h008);
    result(3'h7, 12'hfff);
    host.rd(ALARM0_ADDR, rd);
    chk(rd, 8'h02);
    // Temperature limits compare signed
    result(TEMP_CHAN, 12'h900);
    host.rd(ALARM1_ADDR, rd);
    chk(rd, 8'h00);
    host.wr(8'h97, 8'h0f);
    result(TEMP_CHAN, 12'h100);
    host.rd(ALARM1_ADDR, rd);
    chk(rd, 8'h00);
    result(TEMP_CHAN, 12'he00);
    host.rd(ALARM1_ADDR, rd);
    chk(rd, 8'h01);
    // A stop during direct conversion returns to idle with no fresh data
    @(posedge clock) autoMode <= 1'b0;
    pulse(0);
    pulse(1);
    host.rd(STATUS_ADDR, rd);
    chk(rd, 8'hae);
    // Mid-run reset: pins released again and limits restored
    @(posedge clock) nrst <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk(ioPinOe_q, 8'h00);
    @(posedge clock) nrst <= 1'b1;
    host.rd(8'h80, rd);
    chk(rd, 8'hff);
    give_verdict();
  end
endmodule

bind status_gpio_threshold_regs status_gpio_monitor mon (.clock(clock), .nrst(nrst),
  .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
  .regRdata_q(regRdata_q), .autoMode(autoMode), .convStart(convStart),
  .convStop(convStop), .convDone(convDone), .rangeDetect(rangeDetect),
  .ioPinIn(ioPinIn), .ioPinOut_q(ioPinOut_q), .ioPinOe_q(ioPinOe_q));

`default_nettype wire
